/* src/fsec_map.svh */
/*
 * Command codes, status bit positions and timing figures of the flash
 * suspend, reset and ECC control block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef FSEC_MAP_SVH
`define FSEC_MAP_SVH

`define FSEC_CMD_NOP        8'h00
`define FSEC_CMD_READ3      8'h03
`define FSEC_CMD_READ4      8'h13
`define FSEC_CMD_FREAD3     8'h0B
`define FSEC_CMD_FREAD4     8'h0C
`define FSEC_CMD_OREAD      8'hEC
`define FSEC_CMD_ODREAD     8'hEE
`define FSEC_CMD_PTABLE     8'h5A
`define FSEC_CMD_PTABLE_X   8'hA5
`define FSEC_CMD_ID         8'h9F
`define FSEC_CMD_BURST      8'hC0
`define FSEC_CMD_ENSO       8'hB1
`define FSEC_CMD_EXSO       8'hC1
`define FSEC_CMD_WRITE_ENABLE_COMMAND       8'h06
`define FSEC_CMD_RESUME     8'h30
`define FSEC_CMD_SUSPEND    8'hB0
`define FSEC_CMD_RDLOCK     8'h2D
`define FSEC_CMD_RDSPB      8'hE2
`define FSEC_CMD_RDFBR      8'h16
`define FSEC_CMD_RDDPB      8'hE0
`define FSEC_CMD_RDCFG2     8'h71
`define FSEC_CMD_WRCFG2     8'h72
`define FSEC_CMD_WRITE_DISABLE_COMMAND       8'h04
`define FSEC_CMD_RDST       8'h05
`define FSEC_CMD_RDCFG      8'h15
`define FSEC_CMD_RDSEC      8'h2B
`define FSEC_CMD_RES        8'hAB
`define FSEC_CMD_ARM        8'h66
`define FSEC_CMD_EXEC       8'h99
`define FSEC_CMD_PP         8'h02
`define FSEC_CMD_SE         8'h20

`define FSEC_A_TOP_00       2'b00
`define FSEC_A_TOP_01       2'b01
`define FSEC_A_TOP_10       2'b10

`define FSEC_SEC_PSB        2
`define FSEC_SEC_ESB        3

`define FSEC_SPI_ADDR_BYTES 3
`define FSEC_SPI_DUMMY      8
`define FSEC_OCT_ADDR_BYTES 4
`define FSEC_OCT_DUMMY      20

`define FSEC_CHUNKS         16
`define FSEC_ECC_CLEAR      3'h0

`define FSEC_CLK_NS         100
`define FSEC_SUSP_LAT_US    20
`define FSEC_PP_US          1000
`define FSEC_SE_US          25000

`endif

/* src/fsec_pkg.sv */
/*
 * Types of the flash suspend, reset and ECC control block.
 * Assumes fsec_map.svh for the figures the types use.
 */
`include "fsec_map.svh"

package fsec_pkg;

	typedef enum logic [3:0] {
		FSEC_IDLE    = 4'b0001,
		FSEC_BUSY    = 4'b0010,
		FSEC_SUSPING = 4'b0100,
		FSEC_SUSP    = 4'b1000
	} fsec_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [1:0] addr_top;
	} fsec_cmd_s;

	typedef struct packed {
		logic [2:0] err_type;
		logic [3:0] fail_count;
		logic [3:0] first_chunk;
		logic [31:0] first_addr;
	} fsec_ecc_s;

endpackage

/* src/fsec_ctrl.sv */
/*
 * Command-level control of a serial/octal NOR flash: suspend and resume,
 * two-step software reset, no-operation, parameter-table read phases and
 * per-chunk ECC bookkeeping and reporting.
 * Assumes the command decoder on the same clock hands over one decoded
 * command per pulse, and the array engine reports completion and ECC
 * results on the same clock.
 */
// Contract
// - Latency-gated commands accepted in suspend after latency
// - Listed commands accepted in suspend at once
// - Resume sets latch and busy, clears suspend flag
// - Resumed operation continues until done or suspended
// - Completion clears latch and busy bits
// - No-operation only cancels pending reset arm
// - Arm then execute restores power-on defaults; the code keeps chunk rewrite tracking (ECC-off chunks) across it
// - Execute acts only right after arm
// - Software reset aborts running program or erase
// - Single-line table read: cmd, 3 addr, 8 dummy
// - Octal table read: 4 addr, 20 dummy
// - Hamming code corrects one bit per chunk
// - Page split into sixteen 16-byte chunks
// - Rewritten chunk loses ECC until sector erase
// - ECC reports type, count, first failing chunk
// - ECC reports cleared by write or reset
// - Suspend clears latch, sets program or erase flag
`timescale 1ns/10ps
`default_nettype none
`include "fsec_map.svh"

module fsec_ctrl (
	input  wire logic              clk,            // 10 MHz clock
	input  wire logic              rst_n,          // Synchronous reset, active low
	input  wire fsec_pkg::fsec_cmd_s cmd,          // Decoded command pulse
	input  wire logic              octal_mode,     // Octal single or double rate
	input  wire logic              double_rate,    // Octal double-rate mode
	input  wire logic              op_done,        // Array engine finished
	input  wire logic              ecc_event,      // Read found a chunk error
	input  wire logic [2:0]        ecc_type,       // Error type of that event
	input  wire logic [31:0]       ecc_addr,       // Address of that chunk
	input  wire logic              prog_chunk,     // Program touches a chunk
	input  wire logic [3:0]        prog_chunk_idx, // Chunk index in the page
	input  wire logic              sector_erased,  // Sector erase finished
	input  wire logic              ecc_wr,         // Write to ECC status field
	input  wire logic [2:0]        ecc_wr_data,    // Data of that write
	output logic                   cmd_accept,     // Command taken
	output logic                   cmd_reject,     // Command refused
	output logic                   write_enable_latch, // Latch bit
	output logic                   write_in_progress,  // Busy bit
	output logic                   program_suspended_flag, // Program suspended
	output logic                   erase_suspended_flag,   // Erase suspended
	output logic                   op_run,         // Array engine may run
	output logic                   op_abort,       // Abort pulse to engine
	output logic                   soft_reset,     // Defaults restore pulse
	output logic [2:0]             addr_bytes,     // Table-read address bytes
	output logic [4:0]             dummy_cycles,   // Table-read dummy cycles
	output logic                   addr_align_err, // Odd double-rate address
	output logic                   chunk_ecc_on,   // ECC live for chunk
	output fsec_pkg::fsec_ecc_s    ecc_report      // ECC reporting fields
);

	localparam int SUSP_CYC = (`FSEC_SUSP_LAT_US * 1000 + `FSEC_CLK_NS - 1) / `FSEC_CLK_NS;

	fsec_pkg::fsec_state_e state;
	fsec_pkg::fsec_state_e next_state;
	logic [7:0]  lat_cnt;
	logic        is_erase;
	logic        arm;
	logic [`FSEC_CHUNKS-1:0] chunk_written;
	logic [`FSEC_CHUNKS-1:0] chunk_off;

	function automatic logic is_code(input logic [7:0] c, input logic [7:0] k);
		return c == k;
	endfunction

	wire logic [7:0] c = cmd.code;
	wire logic gated_cmd = is_code(c, `FSEC_CMD_READ3) | is_code(c, `FSEC_CMD_READ4)
		| is_code(c, `FSEC_CMD_FREAD3) | is_code(c, `FSEC_CMD_FREAD4)
		| is_code(c, `FSEC_CMD_OREAD) | is_code(c, `FSEC_CMD_ODREAD)
		| is_code(c, `FSEC_CMD_PTABLE) | is_code(c, `FSEC_CMD_ID)
		| is_code(c, `FSEC_CMD_BURST) | is_code(c, `FSEC_CMD_ENSO)
		| is_code(c, `FSEC_CMD_EXSO) | is_code(c, `FSEC_CMD_WRITE_ENABLE_COMMAND)
		| is_code(c, `FSEC_CMD_RESUME) | is_code(c, `FSEC_CMD_RDLOCK)
		| is_code(c, `FSEC_CMD_RDSPB) | is_code(c, `FSEC_CMD_RDFBR)
		| is_code(c, `FSEC_CMD_RDDPB)
		| (is_code(c, `FSEC_CMD_RDCFG2) & (cmd.addr_top == `FSEC_A_TOP_00
			| cmd.addr_top == `FSEC_A_TOP_01))
		| (is_code(c, `FSEC_CMD_WRCFG2) & cmd.addr_top == `FSEC_A_TOP_00);
	wire logic free_cmd = is_code(c, `FSEC_CMD_WRITE_DISABLE_COMMAND) | is_code(c, `FSEC_CMD_RDST)
		| is_code(c, `FSEC_CMD_RDCFG) | is_code(c, `FSEC_CMD_RDSEC)
		| is_code(c, `FSEC_CMD_RES) | is_code(c, `FSEC_CMD_ARM)
		| is_code(c, `FSEC_CMD_EXEC) | is_code(c, `FSEC_CMD_NOP)
		| ((is_code(c, `FSEC_CMD_RDCFG2) | is_code(c, `FSEC_CMD_WRCFG2))
			& cmd.addr_top == `FSEC_A_TOP_10);
	wire logic lat_done = lat_cnt == 8'(SUSP_CYC);
	wire logic in_susp = state == fsec_pkg::FSEC_SUSPING || state == fsec_pkg::FSEC_SUSP;
	wire logic susp_ok = free_cmd | (gated_cmd & state == fsec_pkg::FSEC_SUSP & lat_done);
	wire logic accept = cmd.valid & (!in_susp | susp_ok);
	wire logic is_exec = accept & is_code(c, `FSEC_CMD_EXEC);
	wire logic do_reset = is_exec & arm;
	wire logic is_resume = accept & is_code(c, `FSEC_CMD_RESUME) & state == fsec_pkg::FSEC_SUSP;
	wire logic is_suspend = accept & is_code(c, `FSEC_CMD_SUSPEND) & state == fsec_pkg::FSEC_BUSY;
	wire logic start_op = accept & state == fsec_pkg::FSEC_IDLE & write_enable_latch
		& (is_code(c, `FSEC_CMD_PP) | is_code(c, `FSEC_CMD_SE));
	wire logic ecc_clr = do_reset | (ecc_wr & ecc_wr_data == `FSEC_ECC_CLEAR);

	assign cmd_accept = accept;
	assign cmd_reject = cmd.valid & !accept;
	assign op_run = state == fsec_pkg::FSEC_BUSY;
	assign chunk_ecc_on = !chunk_off[prog_chunk_idx];

	always_comb begin
		next_state = state;
		case (state)
			fsec_pkg::FSEC_IDLE: begin
				if (start_op)
					next_state = fsec_pkg::FSEC_BUSY;
			end
			fsec_pkg::FSEC_BUSY: begin
				if (is_suspend)
					next_state = fsec_pkg::FSEC_SUSPING;
				else if (op_done)
					next_state = fsec_pkg::FSEC_IDLE;
			end
			fsec_pkg::FSEC_SUSPING: begin
				if (lat_done)
					next_state = fsec_pkg::FSEC_SUSP;
			end
			fsec_pkg::FSEC_SUSP: begin
				if (is_resume)
					next_state = fsec_pkg::FSEC_BUSY;
			end
			default: next_state = fsec_pkg::FSEC_IDLE;
		endcase
		if (do_reset)
			next_state = fsec_pkg::FSEC_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= fsec_pkg::FSEC_IDLE;
			lat_cnt <= 8'h00;
			is_erase <= 1'b0;
		end else begin
			state <= next_state;
			if (next_state == fsec_pkg::FSEC_SUSPING && state != fsec_pkg::FSEC_SUSPING)
				lat_cnt <= 8'h00;
			else if (in_susp && !lat_done)
				lat_cnt <= lat_cnt + 8'h01;
			if (start_op)
				is_erase <= is_code(c, `FSEC_CMD_SE);
		end
	end

	// Any command other than arm drops the arming, refused ones too
	always_ff @(posedge clk) begin
		if (!rst_n)
			arm <= 1'b0;
		else if (cmd.valid)
			arm <= is_code(c, `FSEC_CMD_ARM);
	end

	always_ff @(posedge clk) begin
		if (!rst_n || do_reset) begin
			write_enable_latch <= 1'b0;
			write_in_progress <= 1'b0;
			program_suspended_flag <= 1'b0;
			erase_suspended_flag <= 1'b0;
		end else if (is_resume) begin
			write_enable_latch <= 1'b1;
			write_in_progress <= 1'b1;
			program_suspended_flag <= 1'b0;
			erase_suspended_flag <= 1'b0;
		end else if (state == fsec_pkg::FSEC_SUSPING && lat_done) begin
			write_enable_latch <= 1'b0;
			program_suspended_flag <= !is_erase;
			erase_suspended_flag <= is_erase;
		end else if (state == fsec_pkg::FSEC_BUSY && op_done && !is_suspend) begin
			write_enable_latch <= 1'b0;
			write_in_progress <= 1'b0;
		end else if (start_op) begin
			write_in_progress <= 1'b1;
		end else if (accept && is_code(c, `FSEC_CMD_WRITE_ENABLE_COMMAND)) begin
			write_enable_latch <= 1'b1;
		end else if (accept && is_code(c, `FSEC_CMD_WRITE_DISABLE_COMMAND)) begin
			write_enable_latch <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			op_abort <= 1'b0;
		else
			op_abort <= do_reset & (state != fsec_pkg::FSEC_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			soft_reset <= 1'b0;
		else
			soft_reset <= do_reset;
	end

	// Table-read phase lengths and alignment check
	always_ff @(posedge clk) begin
		if (!rst_n || do_reset) begin
			addr_bytes <= 3'(`FSEC_SPI_ADDR_BYTES);
			dummy_cycles <= 5'(`FSEC_SPI_DUMMY);
			addr_align_err <= 1'b0;
		end else if (accept && is_code(c, `FSEC_CMD_PTABLE)) begin
			addr_bytes <= octal_mode ? 3'(`FSEC_OCT_ADDR_BYTES) : 3'(`FSEC_SPI_ADDR_BYTES);
			dummy_cycles <= octal_mode ? 5'(`FSEC_OCT_DUMMY) : 5'(`FSEC_SPI_DUMMY);
			addr_align_err <= 1'b0;
		end else if (accept && octal_mode && double_rate && is_code(c, `FSEC_CMD_PTABLE_X)) begin
			addr_align_err <= 1'b1;
		end
	end

	// Chunk rewrite tracking: second program of a chunk switches ECC off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chunk_written <= '0;
			chunk_off <= '0;
		end else begin
			if (sector_erased) begin
				chunk_written <= '0;
				chunk_off <= '0;
			end
			// A program in the erase cycle wins over the erase
			if (prog_chunk) begin
				chunk_written[prog_chunk_idx] <= 1'b1;
				if (chunk_written[prog_chunk_idx] && !sector_erased)
					chunk_off[prog_chunk_idx] <= 1'b1;
			end
		end
	end

	// Error reporting; new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ecc_report <= '0;
		end else if (ecc_event) begin
			ecc_report.err_type <= ecc_type;
			if (ecc_clr || ecc_report.fail_count == 4'h0) begin
				ecc_report.first_addr <= ecc_addr;
				ecc_report.first_chunk <= ecc_addr[7:4];
			end
			if (ecc_clr)
				ecc_report.fail_count <= 4'h1;
			else if (ecc_report.fail_count != 4'hF)
				ecc_report.fail_count <= ecc_report.fail_count + 4'h1;
		end else if (ecc_clr) begin
			ecc_report <= '0;
		end
	end

endmodule

`default_nettype wire

/* testbench/fsec_host.sv */
/* Host controller model: issues one decoded command at a time.
   Assumes the control block samples commands on the rising edge. */
`timescale 1ns/10ps
`default_nettype none
module fsec_host #(
	parameter int RECOVER = 20 // Shortened reset recovery wait
) (
	input  wire logic                clk,    // Controller clock
	output var  fsec_pkg::fsec_cmd_s cmd,    // Command strobe
	input  wire logic                accept, // Command taken
	input  wire logic                reject  // Command refused
);
	logic took;
	logic refused;
	initial cmd = '0;
	// One cycle of valid from a falling edge, then a quiet cycle
	task automatic send(input logic [7:0] code, input logic [1:0] top);
		@(negedge clk);
		cmd = {1'b1, code, top};
		#1;
		took = accept;
		refused = reject;
		@(negedge clk);
		cmd = '0;
		if (code == 8'h99)
			repeat (RECOVER) @(negedge clk);
	endtask
endmodule
`default_nettype wire

/* testbench/fsec_ctrl_chk.sv */
/* Port checker for fsec_ctrl, bound into it.
   Assumes one clock and the synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module fsec_ctrl_chk (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire fsec_pkg::fsec_cmd_s cmd,
	input wire logic                op_done,
	input wire logic                ecc_event,
	input wire logic [31:0]         ecc_addr,
	input wire logic                cmd_accept,
	input wire logic                write_enable_latch,
	input wire logic                write_in_progress,
	input wire logic                program_suspended_flag,
	input wire logic                erase_suspended_flag,
	input wire logic                op_run,
	input wire logic                soft_reset,
	input wire fsec_pkg::fsec_ecc_s ecc_report
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic       armed, pend;
	logic [8:0] wait_n;
	wire        take  = cmd.valid & cmd_accept;
	wire        susp  = program_suspended_flag | erase_suspended_flag;
	wire        go    = take & (cmd.code == 8'h99) & armed;
	wire [3:0]  chunk = ecc_addr[7:4];
	// Arming tracker and suspend latency counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed  <= 1'b0;
			pend   <= 1'b0;
			wait_n <= 9'h000;
		end else begin
			if (cmd.valid)
				armed <= cmd.code == 8'h66;
			if (take & op_run & (cmd.code == 8'hB0))
				pend <= 1'b1;
			else if (susp)
				pend <= 1'b0;
			wait_n <= pend ? wait_n + 9'h001 : 9'h000;
		end
	end
	sequence s_pulse;
		soft_reset ##1 !soft_reset;
	endsequence
	a_reset_pulse: assert property (go |=> s_pulse)
		else $error("soft reset pulse missing");
	a_arm_needed: assert property (!go |=> !soft_reset)
		else $error("soft reset without arming");
	a_reset_clear: assert property (soft_reset |-> ecc_report == '0
		&& !write_enable_latch && !write_in_progress && !susp)
		else $error("soft reset left state");
	a_resume_bits: assert property (take && cmd.code == 8'h30 && susp
		|=> write_enable_latch && write_in_progress && !susp)
		else $error("resume did not set bits");
	a_done_clear: assert property (op_done && op_run
		|=> !write_enable_latch && !write_in_progress)
		else $error("completion left bits set");
	a_gate_wait: assert property (pend && !susp && cmd.valid
		&& cmd.code == 8'h03 |-> !cmd_accept)
		else $error("read taken before latency");
	a_free_cmd: assert property (cmd.valid
		&& cmd.code inside {8'h00, 8'h04, 8'h05, 8'h15, 8'h2B, 8'h66} |-> cmd_accept)
		else $error("free command refused");
	a_suspend_wait: assert property ($rose(susp) |-> wait_n inside {[9'h0C6:9'h0CA]})
		else $error("suspend latency off");
	a_first_chunk: assert property (ecc_event && ecc_report.fail_count == 4'h0
		|=> ecc_report.first_chunk == $past(chunk) && ecc_report.fail_count == 4'h1)
		else $error("first failing chunk wrong");
endmodule
bind fsec_ctrl fsec_ctrl_chk fsec_ctrl_chk_i (.*);
`default_nettype wire

/* testbench/fsec_ctrl_test.sv */
/* Self-checking bench of fsec_ctrl driven through the host model.
   Assumes the checker is bound and a 10 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module fsec_ctrl_test;
	logic                clk = 1'b0, rst_n = 1'b0, octal_mode = 1'b0, double_rate = 1'b0;
	logic                op_done = 1'b0, ecc_event = 1'b0, prog_chunk = 1'b0;
	logic                sector_erased = 1'b0, ecc_wr = 1'b0;
	logic [2:0]          ecc_type = 3'h0, ecc_wr_data = 3'h0, addr_bytes;
	logic [3:0]          prog_chunk_idx = 4'h0;
	logic [31:0]         ecc_addr = 32'h0000_0000;
	logic                cmd_accept, cmd_reject, op_run, op_abort, soft_reset;
	logic                write_enable_latch, write_in_progress, addr_align_err;
	logic                program_suspended_flag, erase_suspended_flag, chunk_ecc_on;
	logic [4:0]          dummy_cycles;
	fsec_pkg::fsec_ecc_s ecc_report;
	fsec_pkg::fsec_cmd_s cmd;
	int                  n_fail = 0, num_checks = 0, n_rst = 0, n_abt = 0;
	logic [7:0]          seq [6] = '{8'h66, 8'h00, 8'h99, 8'h66, 8'h05, 8'h99};
	wire [3:0]           flags_now = {write_enable_latch, write_in_progress,
		program_suspended_flag, erase_suspended_flag};
	wire [8:0]           table_now = {addr_bytes, dummy_cycles, addr_align_err};
	fsec_ctrl fsec_ctrl_i (.*);
	fsec_host #(.RECOVER(20)) fsec_host_i (.clk(clk), .cmd(cmd), .accept(cmd_accept),
		.reject(cmd_reject));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (soft_reset)
			n_rst++;
		if (op_abort)
			n_abt++;
	end
	task automatic check(input string what, input logic [42:0] exp, input logic [42:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmd_is(input logic [7:0] c, input logic [1:0] t, input logic ok);
		fsec_host_i.send(c, t);
		check("accept", ok, fsec_host_i.took);
		check("reject", !ok, fsec_host_i.refused);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check("reset", {3'h3, 5'h08, 1'b0}, table_now);
		check("reset", 6'h01, {flags_now, op_run, chunk_ecc_on});
		// Program, then erase: start, suspend, resume, finish
		for (int i = 0; i < 2; i++) begin
			cmd_is(8'h06, 2'b00, 1'b1);
			cmd_is(i ? 8'h20 : 8'h02, 2'b00, 1'b1);
			check("run", 1'b1, op_run);
			cmd_is(8'hB0, 2'b00, 1'b1);
			cmd_is(8'h66, 2'b00, 1'b1);
			cmd_is(8'h03, 2'b00, 1'b0);
			cmd_is(8'h99, 2'b00, 1'b1);
			cmd_is(8'h05, 2'b00, 1'b1);
			repeat (200) @(negedge clk);
			check("suspend", {1'b0, i == 0, i == 1}, {flags_now[3], flags_now[1:0]});
			cmd_is(8'h72, 2'b01, 1'b0);
			cmd_is(8'h72, 2'b10, 1'b1);
			cmd_is(8'h03, 2'b00, 1'b1);
			cmd_is(8'h30, 2'b00, 1'b1);
			check("resume", 4'b1100, flags_now);
			check("run", 1'b1, op_run);
			pulse(op_done);
			check("done", 2'b00, flags_now[3:2]);
		end
		foreach (seq[k])
			fsec_host_i.send(seq[k], 2'b00);
		check("resets", 0, n_rst);
		cmd_is(8'h5A, 2'b00, 1'b1);
		check("table", {3'h3, 5'h08}, {addr_bytes, dummy_cycles});
		octal_mode = 1'b1;
		double_rate = 1'b1;
		cmd_is(8'hA5, 2'b00, 1'b1);
		check("align", 1'b1, addr_align_err);
		cmd_is(8'h5A, 2'b00, 1'b1);
		check("table", {3'h4, 5'h14, 1'b0}, table_now);
		cmd_is(8'hA5, 2'b00, 1'b1);
		octal_mode = 1'b0;
		double_rate = 1'b0;
		prog_chunk_idx = 4'h5;
		pulse(prog_chunk);
		check("chunk", 1'b1, chunk_ecc_on);
		pulse(prog_chunk);
		check("chunk", 1'b0, chunk_ecc_on);
		prog_chunk_idx = 4'h6;
		#1;
		check("chunk", 1'b1, chunk_ecc_on);
		prog_chunk_idx = 4'h5;
		pulse(sector_erased);
		check("chunk", 1'b1, chunk_ecc_on);
		ecc_type = 3'h2;
		ecc_addr = 32'h0000_0150;
		pulse(ecc_event);
		check("ecc", {3'h2, 4'h1, 4'h5, 32'h0000_0150}, ecc_report);
		ecc_addr = 32'h0000_0230;
		repeat (15) pulse(ecc_event);
		check("ecc", {4'hF, 4'h5}, ecc_report[39:32]);
		pulse(ecc_wr);
		check("ecc", '0, ecc_report);
		pulse(ecc_event);
		cmd_is(8'h06, 2'b00, 1'b1);
		cmd_is(8'h02, 2'b00, 1'b1);
		fsec_host_i.send(8'h66, 2'b00);
		fsec_host_i.send(8'h99, 2'b00);
		check("resets", 1, n_rst);
		check("aborts", 1, n_abt);
		check("state", 5'h00, {flags_now, op_run});
		check("ecc", '0, ecc_report);
		check("table", {3'h3, 5'h08, 1'b0}, table_now);
		tally_and_finish();
	end
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog expected done seen hang");
		tally_and_finish();
	end
endmodule
`default_nettype wire
